// ---- rtl/simd_slice_pkg.sv ----
// constants and types shared by the simd and fp execute slice
// Operation
// - dot by element: second operand is 64-bit register from four-bit field only
// - dot by element: same second register each pass; first and destination advance
// - dot product extension absent makes any dot encoding undefined
// - quad dot form: odd destination or first source register is undefined
// - dot uses 32-bit lanes; quad processes two registers, otherwise one
// - lane e sums four byte products 4e+i times 4*index+i into destination
// - unsigned select low sign-extends bytes, high zero-extends them
// - dot or select inside conditional block resolved by one constrained choice
// - select precision 00 undefined; 01 undefined without half precision extension
// - precision 01 is 16-bit, 10 is 32-bit; register is field then extension
// - precision 11 is 64-bit; register is extension bit above field
// - condition code is field, xor of its bits, then zero
// - condition field 00 equal, 01 overflow, 10 greater-equal, 11 greater
// - select writes first source when condition holds, else second source
// - half precision select zeroes upper 16 bits of the 32-bit destination
// - select always executes; no general condition check applies
// - select in conditional block: undefined, executes, or behaves as no operation
// - latency and exception response never depend on data or flags
// - left shift by immediate per 8/16/32/64-bit element, overflow bits dropped
// - access controls may make any operation undefined or trapped to hypervisor
package simd_slice_pkg;

  // ****************************************
  // operations, states, encodings
  // ****************************************
  typedef enum logic [1:0] {
    OP_DOT = 2'b00,
    OP_SEL = 2'b01,
    OP_SHL = 2'b10
  } op_e;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_READ  = 2'b01,
    ST_EXEC  = 2'b10,
    ST_WRITE = 2'b11
  } state_e;

  localparam logic [1:0] PREC_NONE   = 2'b00;
  localparam logic [1:0] PREC_HALF   = 2'b01;
  localparam logic [1:0] PREC_SINGLE = 2'b10;
  localparam logic [1:0] PREC_DOUBLE = 2'b11;

  localparam logic [1:0] ESZ_8  = 2'b00;
  localparam logic [1:0] ESZ_16 = 2'b01;
  localparam logic [1:0] ESZ_32 = 2'b10;
  localparam logic [1:0] ESZ_64 = 2'b11;

  // outcome taken for dot or select inside a conditional block
  localparam logic [1:0] CB_UNDEF = 2'b00;
  localparam logic [1:0] CB_EXEC  = 2'b01;
  localparam logic [1:0] CB_NOP   = 2'b10;

  localparam logic [3:0] COND_EQ = 4'h0;
  localparam logic [3:0] COND_VS = 4'h6;
  localparam logic [3:0] COND_GE = 4'ha;
  localparam logic [3:0] COND_GT = 4'hc;

  localparam logic [1:0] STRB_LO   = 2'b01;
  localparam logic [1:0] STRB_HI   = 2'b10;
  localparam logic [1:0] STRB_FULL = 2'b11;

endpackage

// ---- rtl/select_cond_eval.sv ----
// condition evaluation for the fp conditional select
`timescale 1ns/10ps
module select_cond_eval
  import simd_slice_pkg::*;
(
  input  wire logic [1:0] cond_field,
  input  wire logic [3:0] flags,
  output logic            holds
);

  logic [3:0] cond4;
  logic       n_f;
  logic       z_f;
  logic       v_f;

  // ****************************************
  // condition build and flag test
  // ****************************************
  always_comb begin
    cond4 = {cond_field, cond_field[1] ^ cond_field[0], 1'b0};
    n_f   = flags[3];
    z_f   = flags[2];
    v_f   = flags[0];
    // low bit always zero, so no inverted senses
    case (cond4)
      COND_EQ: holds = z_f;
      COND_VS: holds = v_f;
      COND_GE: holds = (n_f == v_f);
      COND_GT: holds = (n_f == v_f) && !z_f;
      default: holds = 1'b0;
    endcase
  end

endmodule

// ---- rtl/byte_dot_lanes.sv ----
// two 32-bit lanes of byte dot product against one indexed element
`timescale 1ns/10ps
module byte_dot_lanes
  import simd_slice_pkg::*;
(
  input  wire logic [63:0] op1,
  input  wire logic [63:0] op2,
  input  wire logic [63:0] acc,
  input  wire logic        index,
  input  wire logic        is_unsigned,
  output logic      [63:0] res
);

  logic [31:0] elem2;

  assign elem2 = index ? op2[63:32] : op2[31:0];

  // ****************************************
  // per lane multiply and accumulate
  // ****************************************
  genvar e;
  generate
    for (e = 0; e < 2; e++) begin : g_lane
      logic signed [19:0] sum;
      always_comb begin
        logic signed [8:0] a9;
        logic signed [8:0] b9;
        a9  = '0;
        b9  = '0;
        sum = '0;
        for (int i = 0; i < 4; i++) begin
          // one extra bit carries sign or zero, so one multiplier serves both
          a9  = {op1[32*e+8*i+7] & ~is_unsigned, op1[32*e+8*i +: 8]};
          b9  = {elem2[8*i+7] & ~is_unsigned, elem2[8*i +: 8]};
          sum = sum + 20'(a9 * b9);
        end
      end
      // wraps modulo 2^32 like the lane itself
      assign res[32*e +: 32] = acc[32*e +: 32] + {{12{sum[19]}}, sum};
    end
  endgenerate

endmodule

// ---- rtl/simd_fp_dot_select_slice.sv ----
// execute slice: byte dot by element, fp conditional select, vector shift left
`timescale 1ns/10ps
module simd_fp_dot_select_slice
  import simd_slice_pkg::*;
#(
  parameter logic [1:0] CBLOCK_CHOICE = CB_UNDEF
) (
  input  wire logic        REF_CLK,
  input  wire logic        RST,
  input  wire logic        ISSUE_VALID,
  input  wire logic [1:0]  ISSUE_OP,
  input  wire logic        D_BIT,
  input  wire logic        N_BIT,
  input  wire logic        M_BIT,
  input  wire logic        Q_BIT,
  input  wire logic        U_BIT,
  input  wire logic [3:0]  DEST_REG_FIELD,
  input  wire logic [3:0]  FIRST_SRC_REG_FIELD,
  input  wire logic [3:0]  SECOND_SRC_REG_FIELD,
  input  wire logic [1:0]  PREC_FIELD,
  input  wire logic [1:0]  SELECT_CONDITION_FIELD,
  input  wire logic [1:0]  SHIFT_ESIZE,
  input  wire logic [5:0]  SHIFT_AMOUNT,
  input  wire logic [3:0]  CONDITION_FLAGS,
  input  wire logic        IN_CONDITIONAL_BLOCK,
  input  wire logic        DOT_PRODUCT_EXT_PRESENT,
  input  wire logic        HALF_PRECISION_EXT_PRESENT,
  input  wire logic        ACCESS_UNDEF,
  input  wire logic        ACCESS_HYP_TRAP,
  input  wire logic [63:0] RF_A_DATA,
  input  wire logic [63:0] RF_B_DATA,
  input  wire logic [63:0] RF_C_DATA,
  output logic             ISSUE_READY,
  output logic             BUSY,
  output logic             DONE,
  output logic             UNDEF_EXC,
  output logic             HYP_TRAP,
  output logic      [4:0]  RF_A_ADDR,
  output logic      [4:0]  RF_B_ADDR,
  output logic      [4:0]  RF_C_ADDR,
  output logic             RF_WE,
  output logic      [4:0]  RF_W_ADDR,
  output logic      [1:0]  RF_WSTRB,
  output logic      [63:0] RF_WDATA
);

  state_e      state_ff, nxt_state;
  op_e         op_ff, nxt_op;
  logic        last_ff, nxt_last;
  logic        uns_ff, nxt_uns;
  logic        idx_ff, nxt_idx;
  logic [1:0]  prec_ff, nxt_prec;
  logic        n_half_ff, nxt_n_half;
  logic        m_half_ff, nxt_m_half;
  logic [1:0]  sel_cond_ff, nxt_sel_cond;
  logic [3:0]  flags_ff, nxt_flags;
  logic        nop_ff, nxt_nop;
  logic [1:0]  shsz_ff, nxt_shsz;
  logic [5:0]  shamt_ff, nxt_shamt;
  logic [4:0]  a_addr_ff, nxt_a_addr;
  logic [4:0]  b_addr_ff, nxt_b_addr;
  logic [4:0]  c_addr_ff, nxt_c_addr;
  logic [1:0]  strb_ff, nxt_strb;
  logic        we_ff, nxt_we;
  logic [63:0] wdata_ff, nxt_wdata;
  logic        done_ff, nxt_done;
  logic        undef_ff, nxt_undef;
  logic        trap_ff, nxt_trap;

  logic        accept, enc_undef, cond_holds;
  logic [63:0] dot_res;
  logic [63:0] shl_res;
  logic [63:0] sel_d;
  logic [31:0] sel_s;

  assign accept      = ISSUE_VALID && (state_ff == ST_IDLE);
  assign ISSUE_READY = (state_ff == ST_IDLE);
  assign BUSY        = (state_ff != ST_IDLE);
  assign DONE        = done_ff;
  assign UNDEF_EXC   = undef_ff;
  assign HYP_TRAP    = trap_ff;
  assign RF_A_ADDR   = a_addr_ff;
  assign RF_B_ADDR   = b_addr_ff;
  assign RF_C_ADDR   = c_addr_ff;
  assign RF_WE       = we_ff;
  assign RF_W_ADDR   = c_addr_ff;
  assign RF_WSTRB    = strb_ff;
  assign RF_WDATA    = wdata_ff;

  // ****************************************
  // datapath units
  // ****************************************
  byte_dot_lanes u_dot (
    .op1         (RF_A_DATA),
    .op2         (RF_B_DATA),
    .acc         (RF_C_DATA),
    .index       (idx_ff),
    .is_unsigned (uns_ff),
    .res         (dot_res)
  );

  select_cond_eval u_cond (
    .cond_field (sel_cond_ff),
    .flags      (flags_ff),
    .holds      (cond_holds)
  );

  always_comb begin
    shl_res = '0;
    case (shsz_ff)
      ESZ_8:
        for (int k = 0; k < 8; k++) shl_res[8*k +: 8] = RF_A_DATA[8*k +: 8] << shamt_ff;
      ESZ_16:
        for (int k = 0; k < 4; k++) shl_res[16*k +: 16] = RF_A_DATA[16*k +: 16] << shamt_ff;
      ESZ_32:
        for (int k = 0; k < 2; k++) shl_res[32*k +: 32] = RF_A_DATA[32*k +: 32] << shamt_ff;
      default: shl_res = RF_A_DATA << shamt_ff;
    endcase
  end

  // condition picks first source, otherwise second
  always_comb begin
    sel_d = cond_holds ? RF_A_DATA : RF_B_DATA;
    sel_s = cond_holds ? (n_half_ff ? RF_A_DATA[63:32] : RF_A_DATA[31:0])
                       : (m_half_ff ? RF_B_DATA[63:32] : RF_B_DATA[31:0]);
    if (prec_ff == PREC_HALF) begin
      sel_s = {16'h0000, sel_s[15:0]};
    end
  end

  // ****************************************
  // issue decode
  // ****************************************
  always_comb begin
    enc_undef = 1'b0;
    case (op_e'(ISSUE_OP))
      OP_DOT: enc_undef = !DOT_PRODUCT_EXT_PRESENT ||
                          (Q_BIT && (DEST_REG_FIELD[0] || FIRST_SRC_REG_FIELD[0])) ||
                          (IN_CONDITIONAL_BLOCK && CBLOCK_CHOICE == CB_UNDEF);
      OP_SEL: enc_undef = (PREC_FIELD == PREC_NONE) ||
                          (PREC_FIELD == PREC_HALF && !HALF_PRECISION_EXT_PRESENT) ||
                          (IN_CONDITIONAL_BLOCK && CBLOCK_CHOICE == CB_UNDEF);
      OP_SHL: enc_undef = Q_BIT && (DEST_REG_FIELD[0] || SECOND_SRC_REG_FIELD[0]);
      default: enc_undef = 1'b1;
    endcase
  end

  // ****************************************
  // sequencer: fixed schedule per operation
  // ****************************************
  always_comb begin
    nxt_state  = state_ff;
    nxt_op     = op_ff;
    nxt_last   = last_ff;
    nxt_uns    = uns_ff;
    nxt_idx    = idx_ff;
    nxt_prec   = prec_ff;
    nxt_n_half = n_half_ff;
    nxt_m_half = m_half_ff;
    nxt_sel_cond = sel_cond_ff;
    nxt_flags  = flags_ff;
    nxt_nop    = nop_ff;
    nxt_shsz   = shsz_ff;
    nxt_shamt  = shamt_ff;
    nxt_a_addr = a_addr_ff;
    nxt_b_addr = b_addr_ff;
    nxt_c_addr = c_addr_ff;
    nxt_strb   = strb_ff;
    nxt_we     = 1'b0;
    nxt_wdata  = wdata_ff;
    nxt_done   = 1'b0;
    nxt_undef  = 1'b0;
    nxt_trap   = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (accept) begin
          nxt_op     = op_e'(ISSUE_OP);
          nxt_last   = !Q_BIT || (op_e'(ISSUE_OP) == OP_SEL);
          nxt_uns    = U_BIT;
          nxt_idx    = M_BIT;
          nxt_prec   = PREC_FIELD;
          nxt_sel_cond = SELECT_CONDITION_FIELD;
          nxt_flags  = CONDITION_FLAGS;
          nxt_nop    = IN_CONDITIONAL_BLOCK && CBLOCK_CHOICE == CB_NOP;
          nxt_shsz   = SHIFT_ESIZE;
          nxt_shamt  = SHIFT_AMOUNT;
          nxt_strb   = STRB_FULL;
          nxt_n_half = N_BIT;
          nxt_m_half = M_BIT;
          nxt_a_addr = {N_BIT, FIRST_SRC_REG_FIELD};
          nxt_b_addr = {1'b0, SECOND_SRC_REG_FIELD};
          nxt_c_addr = {D_BIT, DEST_REG_FIELD};
          if (op_e'(ISSUE_OP) == OP_SEL && PREC_FIELD != PREC_DOUBLE) begin
            // single register number is field then extension; pick the half
            nxt_a_addr = {1'b0, FIRST_SRC_REG_FIELD};
            nxt_b_addr = {1'b0, SECOND_SRC_REG_FIELD};
            nxt_c_addr = {1'b0, DEST_REG_FIELD};
            nxt_strb   = D_BIT ? STRB_HI : STRB_LO;
          end else if (op_e'(ISSUE_OP) == OP_SEL) begin
            nxt_b_addr = {M_BIT, SECOND_SRC_REG_FIELD};
          end else if (op_e'(ISSUE_OP) == OP_SHL) begin
            nxt_a_addr = {M_BIT, SECOND_SRC_REG_FIELD};
          end
          // encoding and access undefined faults rank above the hypervisor trap
          if (enc_undef || ACCESS_UNDEF) begin
            nxt_undef = 1'b1;
          end else if (ACCESS_HYP_TRAP) begin
            nxt_trap = 1'b1;
          end else begin
            nxt_state = ST_READ;
          end
        end
      end
      ST_READ: nxt_state = ST_EXEC;
      ST_EXEC: begin
        nxt_state = ST_WRITE;
        nxt_we    = !nop_ff;
        case (op_ff)
          OP_DOT:  nxt_wdata = dot_res;
          OP_SEL:  nxt_wdata = (prec_ff == PREC_DOUBLE) ? sel_d : {sel_s, sel_s};
          default: nxt_wdata = shl_res;
        endcase
      end
      ST_WRITE: begin
        if (last_ff) begin
          nxt_state = ST_IDLE;
          nxt_done  = 1'b1;
        end else begin
          // second pass: only first source and destination advance
          nxt_last   = 1'b1;
          nxt_a_addr = 5'(a_addr_ff + 5'd1);
          nxt_c_addr = 5'(c_addr_ff + 5'd1);
          nxt_state  = ST_READ;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  // no data-dependent stall anywhere, so latency ignores data and flags
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      state_ff  <= ST_IDLE;
      op_ff     <= OP_DOT;
      last_ff   <= 1'b1;
      uns_ff    <= 1'b0;
      idx_ff    <= 1'b0;
      prec_ff   <= PREC_NONE;
      n_half_ff <= 1'b0;
      m_half_ff <= 1'b0;
      sel_cond_ff <= 2'b00;
      flags_ff  <= 4'h0;
      nop_ff    <= 1'b0;
      shsz_ff   <= ESZ_8;
      shamt_ff  <= 6'h00;
      a_addr_ff <= 5'h00;
      b_addr_ff <= 5'h00;
      c_addr_ff <= 5'h00;
      strb_ff   <= STRB_FULL;
      we_ff     <= 1'b0;
      wdata_ff  <= 64'h0;
      done_ff   <= 1'b0;
      undef_ff  <= 1'b0;
      trap_ff   <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      op_ff     <= nxt_op;
      last_ff   <= nxt_last;
      uns_ff    <= nxt_uns;
      idx_ff    <= nxt_idx;
      prec_ff   <= nxt_prec;
      n_half_ff <= nxt_n_half;
      m_half_ff <= nxt_m_half;
      sel_cond_ff <= nxt_sel_cond;
      flags_ff  <= nxt_flags;
      nop_ff    <= nxt_nop;
      shsz_ff   <= nxt_shsz;
      shamt_ff  <= nxt_shamt;
      a_addr_ff <= nxt_a_addr;
      b_addr_ff <= nxt_b_addr;
      c_addr_ff <= nxt_c_addr;
      strb_ff   <= nxt_strb;
      we_ff     <= nxt_we;
      wdata_ff  <= nxt_wdata;
      done_ff   <= nxt_done;
      undef_ff  <= nxt_undef;
      trap_ff   <= nxt_trap;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // first read follows a fresh issue, so only a second pass must see it unchanged
  property p_dot_b_fixed;
    (state_ff == ST_READ && op_ff == OP_DOT)
      |-> (!RF_B_ADDR[4] && ($past(state_ff) == ST_IDLE || $stable(RF_B_ADDR)));
  endproperty
  a_dot_b_fixed: assert property (p_dot_b_fixed) else $error("dot operand moved");
  property p_no_ext;
    (accept && ISSUE_OP == OP_DOT && !DOT_PRODUCT_EXT_PRESENT) |=> (UNDEF_EXC && !BUSY);
  endproperty
  a_no_ext: assert property (p_no_ext) else $error("dot without extension ran");
  property p_quad_odd;
    (accept && ISSUE_OP == OP_DOT && Q_BIT && DEST_REG_FIELD[0]) |=> UNDEF_EXC;
  endproperty
  a_quad_odd: assert property (p_quad_odd) else $error("odd quad dot register accepted");
  property p_prec_none;
    (accept && ISSUE_OP == OP_SEL && PREC_FIELD == PREC_NONE) |=> UNDEF_EXC;
  endproperty
  a_prec_none: assert property (p_prec_none) else $error("select precision 00 accepted");
  property p_sel_double;
    (RF_WE && op_ff == OP_SEL && prec_ff == PREC_DOUBLE)
      |-> RF_WDATA == ($past(cond_holds) ? $past(RF_A_DATA) : $past(RF_B_DATA));
  endproperty
  a_sel_double: assert property (p_sel_double) else $error("select picked wrong source");
  property p_half_zero;
    (RF_WE && op_ff == OP_SEL && prec_ff == PREC_HALF)
      |-> (RF_WDATA[31:16] == 16'h0000 && RF_WDATA[63:48] == 16'h0000);
  endproperty
  a_half_zero: assert property (p_half_zero) else $error("half select upper bits set");
  property p_sel_writes;
    (accept && ISSUE_OP == OP_SEL && PREC_FIELD == PREC_DOUBLE && !IN_CONDITIONAL_BLOCK &&
     !ACCESS_UNDEF && !ACCESS_HYP_TRAP) |-> ##3 RF_WE ##1 DONE;
  endproperty
  a_sel_writes: assert property (p_sel_writes) else $error("select did not write");
  property p_fixed_latency;
    (state_ff == ST_IDLE && nxt_state == ST_READ && Q_BIT && ISSUE_OP == OP_DOT)
      |-> ##1 !DONE [*6] ##1 DONE;
  endproperty
  a_fixed_latency: assert property (p_fixed_latency) else $error("quad latency off");
  property p_cond_eq;
    (state_ff == ST_EXEC && sel_cond_ff == 2'b00) |-> (cond_holds == flags_ff[2]);
  endproperty
  a_cond_eq: assert property (p_cond_eq) else $error("equal test wrong");

endmodule

// ---- bench/simd_regfile_model.sv ----
// register file model standing behind the execute slice
`timescale 1ns/10ps
module simd_regfile_model (
  input  wire logic        clk,
  input  wire logic [4:0]  a_addr,
  input  wire logic [4:0]  b_addr,
  input  wire logic [4:0]  c_addr,
  input  wire logic        we,
  input  wire logic [4:0]  w_addr,
  input  wire logic [1:0]  wstrb,
  input  wire logic [63:0] wdata,
  output logic      [63:0] a_data,
  output logic      [63:0] b_data,
  output logic      [63:0] c_data
);
  logic [63:0] regs [32];
  // read data lags the address by one cycle, as the slice expects
  always @(posedge clk) begin
    a_data <= regs[a_addr];
    b_data <= regs[b_addr];
    c_data <= regs[c_addr];
    if (we && wstrb[0]) regs[w_addr][31:0] <= wdata[31:0];
    if (we && wstrb[1]) regs[w_addr][63:32] <= wdata[63:32];
  end
endmodule

// ---- bench/simd_fp_dot_select_slice_test.sv ----
// self-checking testbench for the simd and fp execute slice
`timescale 1ns/10ps
module simd_fp_dot_select_slice_test;
  import simd_slice_pkg::*;
  logic        REF_CLK, RST, ISSUE_VALID, D_BIT, N_BIT, M_BIT, Q_BIT, U_BIT;
  logic        IN_CONDITIONAL_BLOCK, DOT_PRODUCT_EXT_PRESENT, HALF_PRECISION_EXT_PRESENT;
  logic        ACCESS_UNDEF, ACCESS_HYP_TRAP, ISSUE_READY, BUSY, DONE, UNDEF_EXC;
  logic        HYP_TRAP, RF_WE;
  logic [1:0]  ISSUE_OP, PREC_FIELD, SELECT_CONDITION_FIELD, SHIFT_ESIZE, RF_WSTRB;
  logic [3:0]  DEST_REG_FIELD, FIRST_SRC_REG_FIELD, SECOND_SRC_REG_FIELD, CONDITION_FLAGS;
  logic [5:0]  SHIFT_AMOUNT;
  logic [4:0]  RF_A_ADDR, RF_B_ADDR, RF_C_ADDR, RF_W_ADDR;
  logic [63:0] RF_A_DATA, RF_B_DATA, RF_C_DATA, RF_WDATA;
  logic [63:0] wd [2];
  logic [4:0]  wa [2];
  logic [1:0]  ws [2];
  int          num_errors, comparisons, cycles, we_n, done_n, und_n, trap_n;
  int          wc [2];
  // env bits: in block, dot ext, half ext, access undefined, access trap
  localparam logic [4:0] ENV_OK = 5'h0c;

  simd_fp_dot_select_slice DUT (.*);
  simd_regfile_model rf (.clk(REF_CLK), .a_addr(RF_A_ADDR), .b_addr(RF_B_ADDR),
    .c_addr(RF_C_ADDR), .we(RF_WE), .w_addr(RF_W_ADDR), .wstrb(RF_WSTRB),
    .wdata(RF_WDATA), .a_data(RF_A_DATA), .b_data(RF_B_DATA), .c_data(RF_C_DATA));

  initial begin
    REF_CLK = 1'b0;
    forever #2 REF_CLK = ~REF_CLK;
  end

  // a hang costs one mismatch and ends the run
  always @(posedge REF_CLK) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      final_report();
    end
  end

  task automatic final_report();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(string what, logic [63:0] exp, logic [63:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_n(string what, int exp, int got);
    comparisons++;
    if (got != exp) begin
      num_errors++;
      $display("Error %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  // ****************************************
  // issue one operation and collect its outcome
  // ****************************************
  task automatic issue(logic [1:0] op, logic [4:0] dd, nn, mm, logic q, u,
                       logic [1:0] prec, cnd, logic [3:0] fl, logic [4:0] env,
                       logic [1:0] esz, logic [5:0] amt);
    @(posedge REF_CLK);
    ISSUE_OP <= op;
    {D_BIT, DEST_REG_FIELD} <= dd;
    {N_BIT, FIRST_SRC_REG_FIELD} <= nn;
    {M_BIT, SECOND_SRC_REG_FIELD} <= mm;
    Q_BIT <= q;
    U_BIT <= u;
    PREC_FIELD <= prec;
    SELECT_CONDITION_FIELD <= cnd;
    CONDITION_FLAGS <= fl;
    SHIFT_ESIZE <= esz;
    SHIFT_AMOUNT <= amt;
    {IN_CONDITIONAL_BLOCK, DOT_PRODUCT_EXT_PRESENT, HALF_PRECISION_EXT_PRESENT,
     ACCESS_UNDEF, ACCESS_HYP_TRAP} <= env;
    ISSUE_VALID <= 1'b1;
    @(posedge REF_CLK);
    ISSUE_VALID <= 1'b0;
    we_n = 0;
    done_n = 0;
    und_n = 0;
    trap_n = 0;
    // n counts edges from the taking edge, which is edge 1; fault pulses stand only in cycle 1
    for (int n = 1; n < 10; n++) begin
      #1;
      if (RF_WE === 1'b1 && we_n < 2) begin
        wa[we_n] = RF_W_ADDR;
        ws[we_n] = RF_WSTRB;
        wd[we_n] = RF_WDATA;
        wc[we_n] = n;
        we_n++;
      end
      if (DONE === 1'b1) done_n = n;
      if (UNDEF_EXC === 1'b1) und_n = n;
      if (HYP_TRAP === 1'b1) trap_n = n;
      if (done_n + und_n + trap_n > 0) break;
      @(posedge REF_CLK);
    end
  endtask

  function automatic logic [63:0] exp_dot(logic [63:0] a, b, c, logic idx, uns);
    logic [63:0] r;
    int          s, x, y;
    for (int e = 0; e < 2; e++) begin
      s = 0;
      for (int i = 0; i < 4; i++) begin
        x = uns ? int'(a[(4*e+i)*8+:8]) : int'($signed(a[(4*e+i)*8+:8]));
        y = uns ? int'(b[(4*idx+i)*8+:8]) : int'($signed(b[(4*idx+i)*8+:8]));
        s += x * y;
      end
      r[e*32+:32] = c[e*32+:32] + 32'(s);
    end
    return r;
  endfunction

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_dot();
    logic [63:0] e0, e1;
    // index 1 of register 5; register 21 holds different bytes
    e0 = exp_dot(rf.regs[19], rf.regs[5], rf.regs[2], 1'b1, 1'b0);
    issue(OP_DOT, 5'h02, 5'h13, 5'h15, 1'b0, 1'b0, 2'h0, 2'h0, 4'h0, ENV_OK, ESZ_8, 6'h0);
    chk_n("dot write cycle", 3, wc[0]);
    chk_n("dot done cycle", 4, done_n);
    chk("dot write addr", 64'h02, 64'(wa[0]));
    chk("dot second addr", 64'h05, 64'(RF_B_ADDR));
    chk("dot signed data", e0, wd[0]);
    // quad, unsigned, odd second field allowed in the indexed form
    e0 = exp_dot(rf.regs[8], rf.regs[7], rf.regs[4], 1'b0, 1'b1);
    e1 = exp_dot(rf.regs[9], rf.regs[7], rf.regs[5], 1'b0, 1'b1);
    issue(OP_DOT, 5'h04, 5'h08, 5'h07, 1'b1, 1'b1, 2'h0, 2'h0, 4'h0, ENV_OK, ESZ_8, 6'h0);
    chk_n("quad writes", 2, we_n);
    chk_n("quad second write cycle", 6, wc[1]);
    chk_n("quad done cycle", 7, done_n);
    chk("quad second addr", 64'h07, 64'(RF_B_ADDR));
    chk("quad addr 1", 64'h05, 64'(wa[1]));
    chk("quad data 0", e0, wd[0]);
    chk("quad data 1", e1, wd[1]);
  endtask

  task automatic t_sel();
    logic [63:0] src;
    logic [31:0] s32;
    logic [3:0]  fl;
    logic        h;
    for (int p = 1; p < 4; p++) begin
      for (int c = 0; c < 4; c++) begin
        for (int f = 0; f < 16; f += 3) begin
          fl = 4'(f);
          h = c == 0 ? fl[2] : c == 1 ? fl[0] : (fl[3] == fl[0]) && !(c == 3 && fl[2]);
          src = h ? rf.regs[8+c] : rf.regs[27];
          s32 = h ? rf.regs[8+c][31:0] : rf.regs[11][63:32];
          if (p == 1) s32 = {16'h0, s32[15:0]};
          issue(OP_SEL, 5'h13, 5'(8 + c), 5'h1b, 1'b0, 1'b0, 2'(p), 2'(c), fl, ENV_OK,
                ESZ_8, 6'h0);
          chk_n("sel write cycle", 3, wc[0]);
          chk("sel addr", p == 3 ? 64'h13 : 64'h03, 64'(wa[0]));
          chk("sel strobe", p == 3 ? 64'h3 : 64'h2, 64'(ws[0]));
          chk("sel data", p == 3 ? src : {s32, s32}, wd[0]);
        end
      end
    end
  endtask

  task automatic t_shl();
    logic [63:0] r;
    int          w, amt;
    for (int z = 0; z < 4; z++) begin
      w = 8 << z;
      amt = w - 3;
      for (int k = 0; k < 64; k++) r[k] = (k % w >= amt) ? rf.regs[28][k-amt] : 1'b0;
      issue(OP_SHL, 5'h0e, 5'h00, 5'h1c, 1'b0, 1'b0, 2'h0, 2'h0, 4'h0, ENV_OK, 2'(z),
            6'(amt));
      chk("shift addr", 64'h0e, 64'(wa[0]));
      chk("shift data", r, wd[0]);
    end
  endtask

  task automatic fault(logic [1:0] op, logic [4:0] dd, nn, logic q, logic [1:0] prec,
                       logic [4:0] env, int u_cyc, int t_cyc);
    issue(op, dd, nn, 5'h01, q, 1'b0, prec, 2'h0, 4'h4, env, ESZ_8, 6'h1);
    chk_n("undefined cycle", u_cyc, und_n);
    chk_n("trap cycle", t_cyc, trap_n);
    chk_n("faulted writes", 0, we_n);
  endtask

  task automatic t_fault();
    fault(OP_DOT, 5'h02, 5'h04, 1'b0, 2'h0, 5'h04, 1, 0);
    fault(OP_DOT, 5'h03, 5'h04, 1'b1, 2'h0, ENV_OK, 1, 0);
    fault(OP_DOT, 5'h02, 5'h09, 1'b1, 2'h0, ENV_OK, 1, 0);
    fault(OP_SEL, 5'h02, 5'h04, 1'b0, 2'h0, ENV_OK, 1, 0);
    fault(OP_SEL, 5'h02, 5'h04, 1'b0, 2'h1, 5'h08, 1, 0);
    fault(OP_DOT, 5'h02, 5'h04, 1'b0, 2'h0, 5'h1c, 1, 0);
    fault(OP_SEL, 5'h02, 5'h04, 1'b0, 2'h3, 5'h1c, 1, 0);
    fault(OP_SHL, 5'h02, 5'h04, 1'b0, 2'h0, 5'h0d, 0, 1);
    fault(OP_SHL, 5'h02, 5'h04, 1'b0, 2'h0, 5'h0f, 1, 0);
  endtask

  initial begin
    {ISSUE_VALID, D_BIT, N_BIT, M_BIT, Q_BIT, U_BIT, IN_CONDITIONAL_BLOCK} = '0;
    {DOT_PRODUCT_EXT_PRESENT, HALF_PRECISION_EXT_PRESENT, ACCESS_UNDEF} = '0;
    {ACCESS_HYP_TRAP, ISSUE_OP, PREC_FIELD, SELECT_CONDITION_FIELD, SHIFT_ESIZE} = '0;
    {DEST_REG_FIELD, FIRST_SRC_REG_FIELD, SECOND_SRC_REG_FIELD, CONDITION_FLAGS} = '0;
    SHIFT_AMOUNT = '0;
    RST = 1'b1;
    // byte patterns with both halves of the signed range
    for (int i = 0; i < 32; i++) rf.regs[i] = 64'h80ff_7f01_c3a5_5a3c ^ {8{8'(i * 29)}};
    repeat (5) @(posedge REF_CLK);
    RST <= 1'b0;
    @(posedge REF_CLK);
    #1;
    chk("ready after reset", 64'h1, 64'(ISSUE_READY));
    chk("busy after reset", 64'h0, 64'(BUSY));
    t_dot();
    t_sel();
    t_shl();
    t_fault();
    final_report();
  end
endmodule
